/* File: otss_top.sv */
// output terminal signal select: routes drive status to two terminals
// assumes drive status inputs come from logic on sys_clk; axi4-lite slave
// Overview of operation
// - code 90/190 routes the life alarm of capacitors, inrush circuit or fan
// - code 91/191 routes the hardware fault output
// - code 95/195 routes maintenance timer, on when count reaches threshold
// - code 96/196 routes the remote output set by software
// - code 99/199 routes fault output, held until fault reset
// - codes 0-99 conduct when active, 100-199 do not conduct when active
// - one function may drive both terminals at once
// - code 11/111 ready output, on when able to run and while running
// - code 0/100 running, on at or above start freq, off stopped or braking
// - restart coasting: ready on except power loss, running off until restart
// - open-collector terminal carries running output after reset
// - relay terminal carries fault output after reset
// - hardware fault output asserts for six internal fault causes
// - any protective trip asserts the fault output
// - relay terminal refuses current average monitor codes 93/193
module otss_top
  import otss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        driveReady,
  input  wire logic        startCmd,
  input  wire logic [15:0] outputFreq,
  input  wire logic        dcBrake,
  input  wire logic        outputStopInput,
  input  wire logic        tripActive,
  input  wire logic [5:0]  hwCause,
  input  wire logic        faultResetReq,
  input  wire logic        powerFail,
  input  wire logic        coasting,
  input  wire logic [3:0]  lifeWarn,
  input  wire logic        maintTick,
  input  wire logic        currentAvgMonitorIn,
  input  wire logic [17:0] detectStatus,
  output logic             openCollectorOn,
  output logic             relayOn,
  output logic             irq
);
  typedef struct packed {
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [15:0] ocSel;
    logic [15:0] relSel;
    logic        remote;
    logic [15:0] startFreq;
    logic [15:0] maintCount;
    logic [15:0] maintThresh;
    logic        fault;
    logic        hwFault;
    logic        lifePrev;
    logic        maintPrev;
    logic [EVW-1:0] irqStat;
    logic [EVW-1:0] irqEn;
  } otss_state_t;

  otss_state_t s_r;
  otss_state_t s_nxt;
  logic            runningOut;
  logic            readyOut;
  logic            lifeAlarmOut;
  logic            maintTimerOut;
  logic            hwAny;
  logic [SIGW-1:0] sigVec;
  // merge a write word into a register under byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge
  // drive status functions
  assign hwAny = |hwCause;
  assign readyOut = driveReady & ~s_r.fault & ~outputStopInput & ~powerFail;
  assign runningOut = readyOut & startCmd & (outputFreq >= s_r.startFreq)
                      & ~dcBrake & ~coasting;
  assign lifeAlarmOut = |lifeWarn;
  assign maintTimerOut = s_r.maintCount >= s_r.maintThresh;

  // signal vector seen by both terminals
  always_comb begin
    sigVec = '0;
    sigVec[IDX_RUN] = runningOut;
    sigVec[IDX_READY] = readyOut;
    sigVec[IDX_FAULT] = s_r.fault;
    sigVec[IDX_HW] = s_r.hwFault;
    sigVec[IDX_LIFE] = lifeAlarmOut;
    sigVec[IDX_MAINT] = maintTimerOut;
    sigVec[IDX_REMOTE] = s_r.remote;
    sigVec[IDX_CAVG] = currentAvgMonitorIn;
    sigVec[SIGW-1:IDX_DET] = detectStatus;
  end

  // bus handshakes, one write and one read in flight
  assign s_axi_awready = ~s_r.awHeld & ~s_r.bValid;
  assign s_axi_wready = ~s_r.wHeld & ~s_r.bValid;
  assign s_axi_arready = ~s_r.rValid;
  assign s_axi_bvalid = s_r.bValid;
  assign s_axi_bresp = s_r.bResp;
  assign s_axi_rvalid = s_r.rValid;
  assign s_axi_rdata = s_r.rData;
  assign s_axi_rresp = s_r.rResp;
  assign irq = |(s_r.irqStat & s_r.irqEn);

  // next state: bus, registers, fault latch, events
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic        doWr;
    logic        frst;
    logic [EVW-1:0] ev;
    logic [EVW-1:0] clr;
    logic [15:0] wc;
    s_nxt = s_r;
    wv = '0;
    rv = '0;
    frst = faultResetReq;
    ev = '0;
    clr = '0;
    wc = '0;
    doWr = s_r.awHeld & s_r.wHeld;
    // collect address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.awHeld = 1'h1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.wHeld = 1'h1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'h0;
    end
    // maintenance count advances on its tick, saturating
    if (maintTick && s_r.maintCount != 16'hFFFF) begin
      s_nxt.maintCount = s_r.maintCount + 16'h0001;
    end
    // register write once both halves are held
    if (doWr) begin
      s_nxt.awHeld = 1'h0;
      s_nxt.wHeld = 1'h0;
      s_nxt.bValid = 1'h1;
      s_nxt.bResp = RESP_OKAY;
      unique case (s_r.awAddr)
        ADDR_OC_SEL: begin
          wv = wmerge({16'h0000, s_r.ocSel}, s_r.wData, s_r.wStrb);
          s_nxt.ocSel = wv[15:0];
        end
        ADDR_REL_SEL: begin
          wv = wmerge({16'h0000, s_r.relSel}, s_r.wData, s_r.wStrb);
          wc = wv[15:0];
          if (wc == CODE_CAVG || wc == CODE_CAVG + CODE_INV) begin
            s_nxt.bResp = RESP_SLVERR;
          end else begin
            s_nxt.relSel = wc;
          end
        end
        ADDR_REMOTE: begin
          if (s_r.wStrb[0]) begin
            s_nxt.remote = s_r.wData[0];
          end
        end
        ADDR_START_F: begin
          wv = wmerge({16'h0000, s_r.startFreq}, s_r.wData, s_r.wStrb);
          s_nxt.startFreq = wv[15:0];
        end
        ADDR_MNT_CNT: begin
          wv = wmerge({16'h0000, s_r.maintCount}, s_r.wData, s_r.wStrb);
          s_nxt.maintCount = wv[15:0];
        end
        ADDR_MNT_THR: begin
          wv = wmerge({16'h0000, s_r.maintThresh}, s_r.wData, s_r.wStrb);
          s_nxt.maintThresh = wv[15:0];
        end
        ADDR_CONTROL: begin
          frst = frst | (s_r.wStrb[0] & s_r.wData[CTL_FRST]);
        end
        ADDR_STATUS, ADDR_IRQ_STAT: begin
          s_nxt.bResp = RESP_OKAY;
        end
        ADDR_IRQ_CLR: begin
          if (s_r.wStrb[0]) begin
            clr = s_r.wData[EVW-1:0];
          end
        end
        ADDR_IRQ_EN: begin
          if (s_r.wStrb[0]) begin
            s_nxt.irqEn = s_r.wData[EVW-1:0];
          end
        end
        default: begin
          s_nxt.bResp = RESP_DECERR;
        end
      endcase
    end
    // register read, answered one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rValid = 1'h1;
      s_nxt.rResp = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_OC_SEL: rv[15:0] = s_r.ocSel;
        ADDR_REL_SEL: rv[15:0] = s_r.relSel;
        ADDR_REMOTE: rv[0] = s_r.remote;
        ADDR_START_F: rv[15:0] = s_r.startFreq;
        ADDR_MNT_CNT: rv[15:0] = s_r.maintCount;
        ADDR_MNT_THR: rv[15:0] = s_r.maintThresh;
        ADDR_CONTROL, ADDR_IRQ_CLR: rv = '0;
        ADDR_STATUS: begin
          rv[ST_OC] = openCollectorOn;
          rv[ST_REL] = relayOn;
          rv[ST_RUN] = runningOut;
          rv[ST_READY] = readyOut;
          rv[ST_FAULT] = s_r.fault;
          rv[ST_HW] = s_r.hwFault;
          rv[ST_LIFE] = lifeAlarmOut;
          rv[ST_MAINT] = maintTimerOut;
        end
        ADDR_IRQ_STAT: rv[EVW-1:0] = s_r.irqStat;
        ADDR_IRQ_EN: rv[EVW-1:0] = s_r.irqEn;
        default: s_nxt.rResp = RESP_DECERR;
      endcase
      s_nxt.rData = rv;
    end else if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'h0;
    end
    // fault latch: a trip sets, a reset clears, a trip wins
    if (tripActive || hwAny) begin
      s_nxt.fault = 1'h1;
    end else if (frst) begin
      s_nxt.fault = 1'h0;
    end
    if (hwAny) begin
      s_nxt.hwFault = 1'h1;
    end else if (frst) begin
      s_nxt.hwFault = 1'h0;
    end
    // rising edges of the alarm functions become events
    s_nxt.lifePrev = lifeAlarmOut;
    s_nxt.maintPrev = maintTimerOut;
    ev[EV_FAULT] = s_nxt.fault & ~s_r.fault;
    ev[EV_HW] = s_nxt.hwFault & ~s_r.hwFault;
    ev[EV_LIFE] = lifeAlarmOut & ~s_r.lifePrev;
    ev[EV_MAINT] = maintTimerOut & ~s_r.maintPrev;
    // sticky status, a new event beats a clear
    s_nxt.irqStat = (s_r.irqStat & ~clr) | ev;
  end

  // state register with reset defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ocSel <= RST_OC_SEL;
      s_r.relSel <= RST_REL_SEL;
      s_r.startFreq <= RST_START_F;
      s_r.maintThresh <= RST_MNT_THR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // two independent terminals on the same signal set
  otss_terminal u_open_collector (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .selCode (s_r.ocSel),
    .sigVec  (sigVec),
    .conduct (openCollectorOn)
  );
  otss_terminal u_relay_contact (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .selCode (s_r.relSel),
    .sigVec  (sigVec),
    .conduct (relayOn)
  );
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_trip;
    tripActive || hwAny;
  endsequence
  sequence s_hold;
    s_r.fault && !faultResetReq && !(s_r.awHeld && s_r.wHeld);
  endsequence
  property p_fault_set;
    s_trip |=> s_r.fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("trip did not set fault");
  property p_fault_hold;
    s_hold |=> s_r.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without reset");
  property p_hw_fault;
    hwAny |=> s_r.hwFault && s_r.fault;
  endproperty
  a_hw_fault: assert property (p_hw_fault) else $error("hw cause missed");
  property p_ready_run;
    (runningOut && s_r.relSel == CODE_READY) |=> relayOn;
  endproperty
  a_ready_run: assert property (p_ready_run) else $error("running without ready");
  property p_brake_off;
    (dcBrake && s_r.ocSel == CODE_RUN) |=> !openCollectorOn;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("running shown in braking");
  property p_coast;
    (coasting && !powerFail && driveReady && !s_r.fault && !outputStopInput)
      |-> (readyOut && !runningOut);
  endproperty
  a_coast: assert property (p_coast) else $error("coasting outputs wrong");
  sequence s_rel_bad;
    s_r.awHeld && s_r.wHeld && s_r.awAddr == ADDR_REL_SEL && s_r.wStrb == 4'hF
      && (s_r.wData[15:0] == CODE_CAVG || s_r.wData[15:0] == CODE_CAVG + CODE_INV);
  endsequence
  property p_rel_reject;
    s_rel_bad |=> $stable(s_r.relSel) && s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_rel_reject: assert property (p_rel_reject) else $error("relay took code 93");
  property p_maint_route;
    (s_r.ocSel == CODE_MAINT && maintTimerOut) |=> openCollectorOn;
  endproperty
  a_maint_route: assert property (p_maint_route) else $error("maint timer not routed");
  property p_none_idle;
    (s_r.relSel == CODE_NONE) |=> !relayOn;
  endproperty
  a_none_idle: assert property (p_none_idle) else $error("no-function code drives relay");
  property p_remote_inv;
    (s_r.ocSel == CODE_REMOTE + CODE_INV && s_r.remote) |=> !openCollectorOn;
  endproperty
  a_remote_inv: assert property (p_remote_inv) else $error("inverted remote conducts");
endmodule : otss_top

/* File: otss_pkg.sv */
// constants shared by the terminal signal select block
// assumes a 32-bit axi4-lite register port and a 125 MHz sys_clk
package otss_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_OC_SEL   = 8'h00;
  localparam logic [7:0] ADDR_REL_SEL  = 8'h04;
  localparam logic [7:0] ADDR_REMOTE   = 8'h08;
  localparam logic [7:0] ADDR_START_F  = 8'h0C;
  localparam logic [7:0] ADDR_MNT_CNT  = 8'h10;
  localparam logic [7:0] ADDR_MNT_THR  = 8'h14;
  localparam logic [7:0] ADDR_CONTROL  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h28;
  // reset values
  localparam logic [15:0] RST_OC_SEL  = 16'h0000;
  localparam logic [15:0] RST_REL_SEL = 16'h0063;
  localparam logic [15:0] RST_START_F = 16'h0000;
  localparam logic [15:0] RST_MNT_THR = 16'hFFFF;
  // selection codes (positive form)
  localparam logic [15:0] CODE_RUN    = 16'h0000;
  localparam logic [15:0] CODE_READY  = 16'h000B;
  localparam logic [15:0] CODE_LIFE   = 16'h005A;
  localparam logic [15:0] CODE_HW     = 16'h005B;
  localparam logic [15:0] CODE_CAVG   = 16'h005D;
  localparam logic [15:0] CODE_MAINT  = 16'h005F;
  localparam logic [15:0] CODE_REMOTE = 16'h0060;
  localparam logic [15:0] CODE_FAULT  = 16'h0063;
  localparam logic [15:0] CODE_NONE   = 16'h270F;
  localparam logic [15:0] CODE_INV    = 16'h0064;
  localparam logic [15:0] CODE_END    = 16'h00C8;
  localparam int          DET_N       = 18;
  // detector functions whose logic lives elsewhere
  localparam logic [15:0] DET_CODES [DET_N] = '{
    16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008, 16'h000C,
    16'h000D, 16'h000E, 16'h000F, 16'h0010, 16'h0019, 16'h001A,
    16'h002E, 16'h002F, 16'h0040, 16'h0046, 16'h0050, 16'h0062};
  // internal signal vector layout
  localparam int SIGW = 26;
  localparam logic [4:0] IDX_RUN = 5'h00;
  localparam logic [4:0] IDX_READY = 5'h01;
  localparam logic [4:0] IDX_FAULT = 5'h02;
  localparam logic [4:0] IDX_HW = 5'h03;
  localparam logic [4:0] IDX_LIFE = 5'h04;
  localparam logic [4:0] IDX_MAINT = 5'h05;
  localparam logic [4:0] IDX_REMOTE = 5'h06;
  localparam logic [4:0] IDX_CAVG = 5'h07;
  localparam logic [4:0] IDX_DET = 5'h08;
  // status register fields
  localparam int ST_OC = 0;
  localparam int ST_REL = 1;
  localparam int ST_RUN = 2;
  localparam int ST_READY = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_HW = 5;
  localparam int ST_LIFE = 6;
  localparam int ST_MAINT = 7;
  localparam int CTL_FRST = 0;
  // interrupt event bits
  localparam int EV_FAULT = 0;
  localparam int EV_HW = 1;
  localparam int EV_LIFE = 2;
  localparam int EV_MAINT = 3;
  localparam int EVW = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // code to {valid, inverted, signal index}
  function automatic logic [6:0] otss_route(input logic [15:0] code);
    logic [15:0] b;
    logic inv;
    logic ok;
    logic [4:0] idx;
    inv = (code >= CODE_INV) && (code < CODE_END);
    b = inv ? code - CODE_INV : code;
    ok = (code < CODE_END);
    idx = IDX_RUN;
    case (b)
      CODE_RUN: idx = IDX_RUN;
      CODE_READY: idx = IDX_READY;
      CODE_FAULT: idx = IDX_FAULT;
      CODE_HW: idx = IDX_HW;
      CODE_LIFE: idx = IDX_LIFE;
      CODE_MAINT: idx = IDX_MAINT;
      CODE_REMOTE: idx = IDX_REMOTE;
      CODE_CAVG: idx = IDX_CAVG;
      default: begin
        ok = 1'h0;
        for (int i = 0; i < DET_N; i++) begin
          if (b == DET_CODES[i]) begin
            ok = (code < CODE_END);
            idx = IDX_DET + 5'(i);
          end
        end
      end
    endcase
    return {ok, inv, idx};
  endfunction : otss_route
endpackage : otss_pkg

/* File: otss_terminal.sv */
// one status output terminal: code decode, polarity and output register
// assumes sel code and signals come from logic on sys_clk
module otss_terminal
  import otss_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic [15:0]           selCode,
  input  wire logic [otss_pkg::SIGW-1:0] sigVec,
  output logic                       conduct
);
  typedef struct packed {
    logic conduct;
  } otss_term_t;

  otss_term_t s_r;
  otss_term_t s_nxt;
  logic [6:0] route;

  // pick the signal, apply polarity, idle when code is unknown
  always_comb begin
    route = otss_route(selCode);
    s_nxt = s_r;
    s_nxt.conduct = route[6] & (sigVec[route[4:0]] ^ route[5]);
  end

  // glitch-free registered terminal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign conduct = s_r.conduct;

  property p_term_invert;
    @(posedge sys_clk) disable iff (!rst_n)
      (route[6] && route[5] && sigVec[route[4:0]]) |=> !conduct;
  endproperty
  a_term_invert: assert property (p_term_invert) else $error("inverted code conducts");

  property p_term_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      !route[6] |=> !conduct;
  endproperty
  a_term_idle: assert property (p_term_idle) else $error("unknown code conducts");
endmodule : otss_terminal

/* File: otss_equip.sv */
// equipment wired to the relay terminal of the select block
// assumes the terminal level is registered on sys_clk
module otss_equip (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        relayIn,
  output logic [15:0]      relaySwitches
);
  timeunit 1ns;
  timeprecision 1ps;
  logic relayLast;
  // counts relay changeovers, a measure of contact wear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      relayLast     <= 1'b0;
      relaySwitches <= 16'h0000;
    end else begin
      relayLast <= relayIn;
      if (relayLast != relayIn) relaySwitches <= relaySwitches + 16'h0001;
    end
  end
endmodule : otss_equip

/* File: otss_tb_top.sv */
// self-checking bench for the terminal signal select block
// assumes an axi4-lite slave answering within a few cycles
module otss_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import otss_pkg::*;
  logic        sys_clk, rst_n, irq, openCollectorOn, relayOn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, lifeWarn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        driveReady, startCmd, dcBrake, outputStopInput, tripActive, faultResetReq;
  logic        powerFail, coasting, maintTick, cavgIn;
  logic [15:0] outputFreq, relaySwitches;
  logic [5:0]  hwCause;
  int          n_fail, n_tests;

  otss_top dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .driveReady, .startCmd, .outputFreq, .dcBrake, .outputStopInput, .tripActive,
    .hwCause, .faultResetReq, .powerFail, .coasting, .lifeWarn, .maintTick,
    .currentAvgMonitorIn(cavgIn), .detectStatus(18'h00000), .openCollectorOn, .relayOn, .irq);
  otss_equip partner (.sys_clk, .rst_n, .relayIn(relayOn), .relaySwitches);

  // free-running system clock
  always #4 sys_clk = ~sys_clk;

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // bounded wait guard
  task automatic guard(inout int n);
    n++;
    if (n > 50) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask : guard

  // n rising edges, then mid-cycle
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : tick

  // bus write; ready sampled mid-cycle, released after the taking edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aTk, wTk, bTk;
    logic [1:0] resp;
    int n;
    n = 0;
    bTk = 1'b0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!bTk) begin
      @(negedge sys_clk);
      aTk = s_axi_awvalid & s_axi_awready;
      wTk = s_axi_wvalid & s_axi_wready;
      bTk = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge sys_clk);
      if (aTk) s_axi_awvalid <= 1'b0;
      if (wTk) s_axi_wvalid <= 1'b0;
      if (bTk) s_axi_bready <= 1'b0;
      guard(n);
    end
    chk({30'h0, resp}, {30'h0, er});
  endtask : axiWr

  // bus read and compare of data and response
  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic aTk, rTk;
    logic [31:0] d;
    logic [1:0] resp;
    int n;
    n = 0;
    rTk = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!rTk) begin
      @(negedge sys_clk);
      aTk = s_axi_arvalid & s_axi_arready;
      rTk = s_axi_rvalid & s_axi_rready;
      {d, resp} = {s_axi_rdata, s_axi_rresp};
      @(posedge sys_clk);
      if (aTk) s_axi_arvalid <= 1'b0;
      if (rTk) s_axi_rready <= 1'b0;
      guard(n);
    end
    chk(d, ed);
    chk({30'h0, resp}, {30'h0, er});
  endtask : axiRd

  // let the terminal registers settle, then check both
  task automatic term(input logic eo, input logic er);
    tick(3);
    chk({31'h0, openCollectorOn}, {31'h0, eo});
    chk({31'h0, relayOn}, {31'h0, er});
  endtask : term

  // fault reset pulse
  task automatic faultClear;
    @(posedge sys_clk);
    faultResetReq <= 1'b1;
    @(posedge sys_clk);
    faultResetReq <= 1'b0;
    tick(3);
  endtask : faultClear

  // switch one routed function on or off
  task automatic setFn(input int f, input logic on);
    case (f)
      0: axiWr(ADDR_REMOTE, {31'h0, on}, RESP_OKAY);
      1: begin
        @(posedge sys_clk);
        lifeWarn <= on ? 4'h4 : 4'h0;
      end
      2: if (on) begin
        @(posedge sys_clk);
        maintTick <= 1'b1;
        @(posedge sys_clk);
        maintTick <= 1'b0;
      end else axiWr(ADDR_MNT_CNT, 32'h0, RESP_OKAY);
      3: begin
        @(posedge sys_clk);
        driveReady <= on;
      end
      default: begin
        @(posedge sys_clk);
        hwCause <= on ? 6'h04 : 6'h00;
        if (!on) faultClear();
      end
    endcase
  endtask : setFn

  // reset values and default routing
  task automatic t_reset;
    term(1'b0, 1'b0);
    axiRd(ADDR_OC_SEL, {16'h0, RST_OC_SEL}, RESP_OKAY);
    axiRd(ADDR_REL_SEL, {16'h0, RST_REL_SEL}, RESP_OKAY);
    axiRd(ADDR_MNT_THR, {16'h0, RST_MNT_THR}, RESP_OKAY);
    @(posedge sys_clk);
    {driveReady, startCmd, outputFreq} <= {2'h3, 16'h0001};
    term(1'b1, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // trip, hold, masked and enabled interrupt, every hardware cause
  task automatic t_fault;
    @(posedge sys_clk);
    tripActive <= 1'b1;
    @(posedge sys_clk);
    tripActive <= 1'b0;
    term(1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
    axiRd(ADDR_STATUS, (32'h1 << ST_REL) | (32'h1 << ST_FAULT), RESP_OKAY);
    axiRd(ADDR_IRQ_STAT, 32'h1 << EV_FAULT, RESP_OKAY);
    axiWr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
    tick(8);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, relayOn}, 32'h1);
    axiWr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    axiWr(ADDR_CONTROL, 32'h1 << CTL_FRST, RESP_OKAY);
    tick(2);
    chk({31'h0, relayOn}, 32'h0);
    axiWr(ADDR_REL_SEL, {16'h0, CODE_HW}, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      hwCause <= 6'h01 << i;
      term(1'b0, 1'b1);
      @(posedge sys_clk);
      hwCause <= 6'h00;
      faultClear();
      chk({31'h0, relayOn}, 32'h0);
    end
    $display("test fault done");
  endtask : t_fault

  // remote, life, maintenance, ready and hw fault, positive on one terminal and inverted on the other
  task automatic t_codes;
    logic [15:0] codes [5] = '{CODE_REMOTE, CODE_LIFE, CODE_MAINT, CODE_READY, CODE_HW};
    axiWr(ADDR_MNT_THR, 32'h1, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      axiWr(ADDR_OC_SEL, {16'h0, codes[i]}, RESP_OKAY);
      axiWr(ADDR_REL_SEL, {16'h0, codes[i] + CODE_INV}, RESP_OKAY);
      setFn(i, 1'b0);
      term(1'b0, 1'b1);
      setFn(i, 1'b1);
      term(1'b1, 1'b0);
      setFn(i, 1'b0);
    end
    setFn(3, 1'b1);
    $display("test codes done");
  endtask : t_codes

  // one drive state, then running and ready on the terminals
  task automatic runCase(input logic [15:0] f, input logic [3:0] bcps, input logic er, input logic ey);
    @(posedge sys_clk);
    outputFreq <= f;
    {dcBrake, coasting, powerFail, outputStopInput} <= bcps;
    term(er, ey);
  endtask : runCase

  // running and ready across drive states
  task automatic t_run;
    axiWr(ADDR_OC_SEL, {16'h0, CODE_RUN}, RESP_OKAY);
    axiWr(ADDR_REL_SEL, {16'h0, CODE_READY}, RESP_OKAY);
    axiWr(ADDR_START_F, 32'hA, RESP_OKAY);
    runCase(16'h0009, 4'h0, 1'b0, 1'b1);
    runCase(16'h000A, 4'h0, 1'b1, 1'b1);
    runCase(16'h000A, 4'h8, 1'b0, 1'b1);
    runCase(16'h000A, 4'h4, 1'b0, 1'b1);
    runCase(16'h000A, 4'h6, 1'b0, 1'b0);
    runCase(16'h000A, 4'h0, 1'b1, 1'b1);
    runCase(16'h000A, 4'h1, 1'b0, 1'b0);
    runCase(16'h000A, 4'h0, 1'b1, 1'b1);
    $display("test run done");
  endtask : t_run

  // refused codes, unmapped place, unused codes, shared function
  task automatic t_refuse;
    logic [15:0] bad [3] = '{CODE_NONE, CODE_END, 16'h0002};
    axiWr(ADDR_REL_SEL, {16'h0, CODE_CAVG}, RESP_SLVERR);
    axiWr(ADDR_REL_SEL, {16'h0, CODE_CAVG + CODE_INV}, RESP_SLVERR);
    axiRd(ADDR_REL_SEL, {16'h0, CODE_READY}, RESP_OKAY);
    axiWr(ADDR_OC_SEL, {16'h0, CODE_CAVG}, RESP_OKAY);
    @(posedge sys_clk);
    cavgIn <= 1'b1;
    term(1'b1, 1'b1);
    axiWr(8'h40, 32'h1, RESP_DECERR);
    axiRd(8'h40, 32'h0, RESP_DECERR);
    for (int i = 0; i < 3; i++) begin
      axiWr(ADDR_OC_SEL, {16'h0, bad[i]}, RESP_OKAY);
      term(1'b0, 1'b1);
    end
    axiWr(ADDR_REL_SEL, {16'h0, CODE_NONE}, RESP_OKAY);
    term(1'b0, 1'b0);
    axiWr(ADDR_OC_SEL, {16'h0, CODE_REMOTE}, RESP_OKAY);
    axiWr(ADDR_REL_SEL, {16'h0, CODE_REMOTE}, RESP_OKAY);
    setFn(0, 1'b1);
    term(1'b1, 1'b1);
    axiWr(ADDR_OC_SEL, {16'h0, CODE_REMOTE + CODE_INV}, RESP_OKAY);
    term(1'b0, 1'b1);
    chk({31'h0, relaySwitches < 16'h0040}, 32'h1);
    $display("test refuse done");
  endtask : t_refuse

  // reset, then the scenarios in turn
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {n_fail, n_tests} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lifeWarn, outputFreq, hwCause} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {driveReady, startCmd, dcBrake, outputStopInput, tripActive} = '0;
    {faultResetReq, powerFail, coasting, maintTick, cavgIn} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_fault();
    t_codes();
    t_run();
    t_refuse();
    test_done();
  end
endmodule : otss_tb_top
